// file: logic/fpc_flash_protection_control.v
// Flash protection gating and control/status register
// Summary of operation
// - Read-out and write/erase protection are independent; either may be on alone.
// - Read-out protection blocks external reads and all flash array writes.
// - Removing read-out protection requests a mass erase of the whole program memory; external reads reopen at once.
// - Read-out protection follows only the option byte read-out bit.
// - Write/erase protection rejects every flash write request; it does not gate the mass erase request.
// - Write/erase protection is activated from the option byte bit.
// - Once set, write/erase protection never clears, even across reset.
// - The control register sets option byte select, latch mode and program start; it has no erase control.
// - Register resets to 00h; bits 7..3 read zero; bits 2..0 are controls.
`timescale 1ns/1ps
`include "fpc_defs.vh"
module fpc_flash_protection_control (
  sys_clk,
  reset,
  bus_addr,
  bus_wdata,
  bus_wr,
  bus_rd,
  bus_rdata,
  readout_protect_option,
  write_erase_protect_option,
  ext_read_req,
  ext_read_grant,
  flash_write_req,
  flash_write_grant,
  mass_erase_req,
  mass_erase_done,
  option_byte_select,
  latch_mode,
  program_start,
  readout_protect_active,
  write_erase_protect_active,
  key_unlocked
);
  input wire sys_clk;
  input wire reset;
  input wire [`FPC_ADDR_W-1:0] bus_addr;
  input wire [7:0] bus_wdata;
  input wire bus_wr;
  input wire bus_rd;
  output reg [7:0] bus_rdata;
  input wire readout_protect_option;
  input wire write_erase_protect_option;
  input wire ext_read_req;
  output reg ext_read_grant;
  input wire flash_write_req;
  output reg flash_write_grant;
  output reg mass_erase_req;
  input wire mass_erase_done;
  output reg option_byte_select;
  output reg latch_mode;
  output reg program_start;
  output reg readout_protect_active;
  output reg write_erase_protect_active;
  output reg key_unlocked;

  wire csr_hit;
  wire csr_wr;
  wire unlocked;
  reg rop_seen_reg;
  reg erase_pend_reg;
  reg wep_sticky_reg;
  wire rop_now;
  wire wep_now;

  assign csr_hit = (bus_addr == `FPC_CSR_OFFSET);
  assign csr_wr = bus_wr && csr_hit;

  // Key bytes arrive by writes to the control register itself
  fpc_key_unlock u_key (
    .sys_clk(sys_clk),
    .reset(reset),
    .key_wr(csr_wr && !unlocked),
    .key_data(bus_wdata),
    .relock(1'b0),
    .unlocked(unlocked)
  );

  // The option byte is nonvolatile, so a set bit simply stays set; the sticky
  // copy also holds the lock if the option input is ever seen low again
  assign wep_now = write_erase_protect_option || wep_sticky_reg;
  assign rop_now = readout_protect_option;

  always @(posedge sys_clk) begin
    if (reset) begin
      rop_seen_reg <= 1'b0;
      erase_pend_reg <= 1'b0;
      mass_erase_req <= 1'b0;
      option_byte_select <= 1'b0;
      latch_mode <= 1'b0;
      program_start <= 1'b0;
      bus_rdata <= 8'h00;
      ext_read_grant <= 1'b0;
      flash_write_grant <= 1'b0;
      readout_protect_active <= 1'b0;
      write_erase_protect_active <= 1'b0;
      key_unlocked <= 1'b0;
    end else begin
      rop_seen_reg <= rop_now;
      // Falling read-out option arms a full erase; writes are blocked from the next cycle until it is done
      if (rop_seen_reg && !rop_now) begin
        erase_pend_reg <= 1'b1;
      end else if (mass_erase_done) begin
        erase_pend_reg <= 1'b0;
      end
      mass_erase_req <= erase_pend_reg && !mass_erase_done;
      if (csr_wr && unlocked) begin
        option_byte_select <= bus_wdata[`FPC_BIT_OPT];
        latch_mode <= bus_wdata[`FPC_BIT_LAT];
        program_start <= bus_wdata[`FPC_BIT_PGM];
      end
      if (bus_rd && csr_hit) begin
        bus_rdata <= {5'h00, option_byte_select, latch_mode, program_start};
      end else begin
        bus_rdata <= 8'h00;
      end
      ext_read_grant <= ext_read_req && !rop_now;
      flash_write_grant <= flash_write_req && unlocked && !rop_now && !wep_now &&
                           !erase_pend_reg;
      readout_protect_active <= rop_now;
      write_erase_protect_active <= wep_now;
      key_unlocked <= unlocked;
    end
  end

  // No reset on purpose: reset must never clear write/erase protection
  initial wep_sticky_reg = 1'b0;
  always @(posedge sys_clk) begin
    if (write_erase_protect_option) begin
      wep_sticky_reg <= 1'b1;
    end
  end
endmodule // fpc_flash_protection_control

// file: logic/fpc_defs.vh
// Constants for the flash protection and control block
`ifndef FPC_DEFS_VH
`define FPC_DEFS_VH
`define FPC_ADDR_W 8
`define FPC_CSR_OFFSET 8'h2f
`define FPC_CSR_RESET 8'h00
`define FPC_KEY1 8'h56
`define FPC_KEY2 8'hae
`define FPC_BIT_PGM 0
`define FPC_BIT_LAT 1
`define FPC_BIT_OPT 2
`define FPC_KEY_IDLE 2'h0
`define FPC_KEY_ONE 2'h1
`define FPC_KEY_OPEN 2'h2
`endif

// file: logic/fpc_key_unlock.v
// Two-byte key detector that unlocks the control register
`timescale 1ns/1ps
`include "fpc_defs.vh"
module fpc_key_unlock (
  sys_clk,
  reset,
  key_wr,
  key_data,
  relock,
  unlocked
);
  input wire sys_clk;
  input wire reset;
  input wire key_wr;
  input wire [7:0] key_data;
  input wire relock;
  output wire unlocked;

  localparam [1:0] ST_IDLE = `FPC_KEY_IDLE;
  localparam [1:0] ST_ONE = `FPC_KEY_ONE;
  localparam [1:0] ST_OPEN = `FPC_KEY_OPEN;

  reg [1:0] state_reg;
  reg [1:0] state_next;

  assign unlocked = (state_reg == ST_OPEN);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (key_wr && key_data == `FPC_KEY1) begin
          state_next = ST_ONE;
        end
      end
      ST_ONE: begin
        if (key_wr) begin
          // A repeated first key restarts the pair rather than failing it
          if (key_data == `FPC_KEY2) begin
            state_next = ST_OPEN;
          end else if (key_data == `FPC_KEY1) begin
            state_next = ST_ONE;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_OPEN: begin
        if (relock) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule // fpc_key_unlock

// file: sim/fpc_properties.sv
// Checker for the flash protection and control block
`timescale 1ns/1ps
module fpc_checker (
  input wire sys_clk,
  input wire reset,
  input wire [7:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire [7:0] bus_rdata,
  input wire readout_protect_option,
  input wire ext_read_grant,
  input wire flash_write_grant,
  input wire mass_erase_req,
  input wire option_byte_select,
  input wire latch_mode,
  input wire program_start,
  input wire readout_protect_active,
  input wire write_erase_protect_active,
  input wire key_unlocked
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Both high avoids a one-cycle lag either way
  wire rop = readout_protect_option && readout_protect_active;
  wire [2:0] ctl = {option_byte_select, latch_mode, program_start};
  property p_ext_rop; rop |=> !ext_read_grant; endproperty
  a_ext_rop: assert property (p_ext_rop) else $error("ext grant");
  property p_wr_rop; rop |=> !flash_write_grant; endproperty
  a_wr_rop: assert property (p_wr_rop) else $error("write grant");
  property p_wr_wep; write_erase_protect_active |=> !flash_write_grant; endproperty
  a_wr_wep: assert property (p_wr_wep) else $error("wep grant");
  property p_wep_hold; write_erase_protect_active |=> write_erase_protect_active; endproperty
  a_wep_hold: assert property (p_wep_hold) else $error("wep cleared");
  property p_rop_follow; readout_protect_option [*2] |-> readout_protect_active; endproperty
  a_rop_follow: assert property (p_rop_follow) else $error("rop off");
  property p_erase; $fell(readout_protect_option) |-> ##[1:2] mass_erase_req; endproperty
  a_erase: assert property (p_erase) else $error("no erase");
  property p_csr; bus_rd && bus_addr == 8'h2f |=> bus_rdata == {5'h00, $past(ctl)}; endproperty
  a_csr: assert property (p_csr) else $error("csr read");
  // Status lags the key state by a cycle, so only judge writes after an idle cycle
  property p_locked; !key_unlocked && bus_wr && !$past(bus_wr) |=> $stable(ctl); endproperty
  a_locked: assert property (p_locked) else $error("locked write");
endmodule // fpc_checker
bind fpc_flash_protection_control fpc_checker u_fpc_checker (.*);

// file: sim/fpc_flash_protection_control_tb.sv
// Self-checking bench for the flash protection and control block
`timescale 1ns/1ps
module fpc_flash_protection_control_tb;
  reg sys_clk = 0, reset = 1, wr = 0, rd = 0, rop = 0, wep = 0, er = 0, fw = 0, dn = 0;
  reg [7:0] a = 8'h00, d = 8'h00;
  wire [7:0] q;
  wire erg, fwg, erq, obs, lm, ps, ropa, wepa, unl;
  integer fail_count = 0, compares = 0;
  always #12.5 sys_clk = ~sys_clk;
  fpc_flash_protection_control u_fpc_flash_protection_control (.sys_clk(sys_clk),
    .reset(reset), .bus_addr(a), .bus_wdata(d), .bus_wr(wr), .bus_rd(rd), .bus_rdata(q),
    .readout_protect_option(rop), .write_erase_protect_option(wep), .ext_read_req(er),
    .ext_read_grant(erg), .flash_write_req(fw), .flash_write_grant(fwg),
    .mass_erase_req(erq), .mass_erase_done(dn), .option_byte_select(obs), .latch_mode(lm),
    .program_start(ps), .readout_protect_active(ropa), .write_erase_protect_active(wepa),
    .key_unlocked(unl));
  task chk(input [7:0] g, input [7:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task w(input [7:0] ad, input [7:0] dat);
    begin
      @(posedge sys_clk);
      a <= ad;
      d <= dat;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
    end
  endtask
  task r(input [7:0] ad, input [7:0] e);
    begin
      @(posedge sys_clk);
      a <= ad;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(negedge sys_clk);
      chk(q, e);
    end
  endtask
  // Status outputs are registered; three cycles lets them settle
  task look(input [7:0] e);
    begin
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({2'b00, unl, wepa, ropa, erq, fwg, erg}, e);
    end
  endtask
  task wrap_up;
    begin
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    r(8'h2f, 8'h00);
    w(8'h2f, 8'h07);
    r(8'h2f, 8'h00);
    w(8'h2f, 8'h56);
    w(8'h2f, 8'h12);
    w(8'h2f, 8'hae);
    look(8'h00);
    $display("locked test done");
    w(8'h2f, 8'h56);
    w(8'h2f, 8'h56);
    w(8'h2f, 8'hae);
    er <= 1'b1;
    fw <= 1'b1;
    look(8'h23);
    w(8'h2f, 8'hff);
    r(8'h2f, 8'h07);
    r(8'h30, 8'h00);
    $display("register test done");
    rop <= 1'b1;
    look(8'h28);
    rop <= 1'b0;
    look(8'h25);
    chk({6'h00, erq, fwg}, 8'h02);
    @(posedge sys_clk);
    dn <= 1'b1;
    @(posedge sys_clk);
    dn <= 1'b0;
    look(8'h23);
    wep <= 1'b1;
    look(8'h31);
    wep <= 1'b0;
    look(8'h31);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    look(8'h11);
    r(8'h2f, 8'h00);
    $display("protection test done");
    wrap_up;
  end
endmodule // fpc_flash_protection_control_tb
